// ===== core/acfg_top.sv
// Setup and filter configuration registers with APB slave and channel sequencing
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`include "acfg_defines.svh"
module acfg_top #(
  parameter int MCLK_DIV = `ACFG_MCLK_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic chan_change,
  input wire logic [2:0] setup_sel,
  input wire logic conv_done,
  output logic conv_start,
  output logic chan_advance,
  output acfg_pkg::acfg_active_t active
);

  logic [15:0] cfg_q [`ACFG_NUM_SETUPS];
  logic [23:0] flt_q [`ACFG_NUM_SETUPS];
  logic [1:0] ctrl_q;
  logic [15:0] div_q;
  logic mclk_en_q;
  acfg_pkg::acfg_state_t state_q;
  logic [2:0] slot_q;
  logic [4:0] rep_left_q;
  logic settle_start_q;
  logic settle_done;
  logic [`ACFG_IDX_W-1:0] idx;
  logic wr_access;
  logic [31:0] rd_word;
  logic rd_hit;
  logic repeat_off;
  acfg_pkg::acfg_setup_t sel_cfg;
  acfg_pkg::acfg_filter_t sel_flt;
  acfg_pkg::acfg_filter_t slot_flt;

  assign idx = paddr[11:2];
  assign wr_access = psel && penable && pwrite && pready;
  assign repeat_off = ctrl_q[`ACFG_CTRL_DUTY_BIT] || ctrl_q[`ACFG_CTRL_CAL_BIT];

  // Register read mux; printed offsets are word indices, byte address is four times that
  always_comb begin
    rd_word = 32'h00000000;
    rd_hit = 1'b0;
    if (idx >= `ACFG_CFG_IDX0 && idx <= `ACFG_CFG_IDX7) begin
      rd_hit = 1'b1;
      rd_word = {16'h0000, cfg_q[3'(idx - `ACFG_CFG_IDX0)]};
    end else if (idx >= `ACFG_FLT_IDX0 && idx <= `ACFG_FLT_IDX7) begin
      rd_hit = 1'b1;
      rd_word = {8'h00, flt_q[3'(idx - `ACFG_FLT_IDX0)]};
    end else if (idx == `ACFG_CTRL_IDX) begin
      rd_hit = 1'b1;
      rd_word = {30'h00000000, ctrl_q};
    end else if (idx == `ACFG_STAT_IDX) begin
      rd_hit = 1'b1;
      rd_word = {19'h00000, rep_left_q, 1'b0, slot_q, 1'b0, state_q};
    end
  end

  // No wait state: answer registered in setup, pready high in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      pslverr <= !rd_hit;
      prdata <= (!pwrite && rd_hit) ? rd_word : 32'h00000000;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
  end

  // Per-slot setup and filter words
  for (genvar g = 0; g < `ACFG_NUM_SETUPS; g++) begin : g_slot
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cfg_q[g] <= `ACFG_CFG_RESET;
      end else if (wr_access && idx == `ACFG_CFG_IDX0 + `ACFG_IDX_W'(g)) begin
        cfg_q[g] <= pwdata[15:0];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        flt_q[g] <= `ACFG_FLT_RESET;
      end else if (wr_access && idx == `ACFG_FLT_IDX0 + `ACFG_IDX_W'(g)) begin
        flt_q[g] <= pwdata[23:0] & ~(24'h000001 << `ACFG_FLT_RSVD_BIT);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `ACFG_CTRL_RESET;
    end else if (wr_access && idx == `ACFG_CTRL_IDX) begin
      ctrl_q <= pwdata[1:0];
    end
  end

  // Master clock enable divided down from pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 16'h0000;
      mclk_en_q <= 1'b0;
    end else if (div_q == 16'(MCLK_DIV - 1)) begin
      div_q <= 16'h0000;
      mclk_en_q <= 1'b1;
    end else begin
      div_q <= div_q + 16'h0001;
      mclk_en_q <= 1'b0;
    end
  end

  assign slot_flt = acfg_pkg::acfg_filter_t'(flt_q[setup_sel]);

  acfg_settle_timer u_settle (
    .pclk(pclk),
    .presetn(presetn),
    .mclk_en(mclk_en_q),
    .start(settle_start_q),
    .code(flt_q[slot_q][23:21]),
    .done(settle_done)
  );

  // Channel sequencing; a channel change always wins and restarts the wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= acfg_pkg::ACFG_ST_IDLE;
      slot_q <= 3'h0;
      rep_left_q <= 5'h00;
      settle_start_q <= 1'b0;
      conv_start <= 1'b0;
      chan_advance <= 1'b0;
    end else begin
      settle_start_q <= 1'b0;
      conv_start <= 1'b0;
      chan_advance <= 1'b0;
      if (chan_change) begin
        slot_q <= setup_sel;
        settle_start_q <= 1'b1;
        rep_left_q <= repeat_off ? 5'h00 : slot_flt.repeat_count;
        state_q <= acfg_pkg::ACFG_ST_SETTLE;
      end else begin
        case (state_q)
          acfg_pkg::ACFG_ST_IDLE: begin
            state_q <= acfg_pkg::ACFG_ST_IDLE;
          end
          acfg_pkg::ACFG_ST_SETTLE: begin
            if (settle_done) begin
              conv_start <= 1'b1;
              state_q <= acfg_pkg::ACFG_ST_CONVERT;
            end
          end
          acfg_pkg::ACFG_ST_CONVERT: begin
            if (conv_done) begin
              if (rep_left_q != 5'h00 && !repeat_off) begin
                rep_left_q <= rep_left_q - 5'h01;
                conv_start <= 1'b1;
              end else begin
                rep_left_q <= 5'h00;
                chan_advance <= 1'b1;
                state_q <= acfg_pkg::ACFG_ST_IDLE;
              end
            end
          end
          default: begin
            state_q <= acfg_pkg::ACFG_ST_IDLE;
          end
        endcase
      end
    end
  end

  assign sel_cfg = acfg_pkg::acfg_setup_t'(cfg_q[slot_q]);
  assign sel_flt = acfg_pkg::acfg_filter_t'(flt_q[slot_q]);

  // Decoded settings of the active slot, registered so the analog side sees clean levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active <= '0;
    end else begin
      active.neg_ref_buffer_on <= cfg_q[slot_q][`ACFG_CFG_NEG_BUF_BIT];
      active.ref_sel <= sel_cfg.ref_sel;
      active.amp_gain_code <= sel_cfg.amp_bypass ? 3'h0 : sel_cfg.amp_gain_code;
      active.gain_factor <= sel_cfg.amp_bypass ? 8'h01 : 8'(8'h01 << sel_cfg.amp_gain_code);
      active.filter_mode <= acfg_pkg::acfg_fmode_t'(sel_flt.mode);
      active.mode_reserved <= sel_flt.mode > acfg_pkg::ACFG_FLT_POST4;
      active.sixty_hz_notch <= sel_flt.mode == acfg_pkg::ACFG_FLT_SINC3_REJ;
      active.fixed_output_rate <= sel_flt.mode >= acfg_pkg::ACFG_FLT_POST1 &&
                                  sel_flt.mode <= acfg_pkg::ACFG_FLT_POST4;
      // Zero divider would stall the decimator, so it runs as one
      active.rate_divider <= (sel_flt.rate_divider == 11'h000) ? 11'h001
                                                                : sel_flt.rate_divider;
    end
  end

endmodule : acfg_top

// ===== core/acfg_defines.svh
// Register map, field positions, reset values and timing counts for the setup/filter config
// Overview of operation
// - Negative reference buffer bit: 0 bypasses the buffer, 1 turns it on.
// - Reference select 00/01 external pairs, 10 internal ref, 11 supply pair.
// - Gain code sets amplifier gain to two to the code, 1 to 128.
// - Bypass bit set forces gain 1 and ignores the gain code.
// - Settling wait is 32 master clocks doubled per code step, up to 4096.
// - Settling wait follows a channel change only, never a repeated conversion.
// - Repeat value N converts the channel N+1 times; zero gives one conversion.
// - Repeat count is ignored under duty cycling or any calibration mode.
// - Filter code picks sinc4, sinc4 avg, sinc3 (reset 2) or sinc3 variants; 9-15 reserved.
// - Filter code 0011 adds a notch at 6/5 of the main notch.
// - Codes 0101-1000 use a post filter with a fixed output rate each.
// - Eleven-bit rate divider resets to 0x30; written zero acts as one.
// - Eight filter words at indices 0x21-0x28, picked by the channel's setup slot.
// - Negative buffer bit is bit 3; reference, gain and bypass sit in bits 5-0.
// - Eight sixteen-bit setup words at indices 0x19-0x20, reset 0x0000.
`ifndef ACFG_DEFINES_SVH
`define ACFG_DEFINES_SVH

`define ACFG_NUM_SETUPS 8
`define ACFG_IDX_W 10
`define ACFG_CFG_IDX0 10'h019
`define ACFG_CFG_IDX7 10'h020
`define ACFG_FLT_IDX0 10'h021
`define ACFG_FLT_IDX7 10'h028
`define ACFG_CTRL_IDX 10'h040
`define ACFG_STAT_IDX 10'h041

`define ACFG_CFG_RESET 16'h0000
`define ACFG_FLT_RESET 24'h002030
`define ACFG_CTRL_RESET 2'h0

`define ACFG_CFG_NEG_BUF_BIT 3
`define ACFG_FLT_RSVD_BIT 11
`define ACFG_CTRL_DUTY_BIT 0
`define ACFG_CTRL_CAL_BIT 1

`define ACFG_SETTLE_BASE 13'h0020
`define ACFG_PCLK_HZ 25000000
`define ACFG_MCLK_HZ 76800
`define ACFG_MCLK_DIV (`ACFG_PCLK_HZ / `ACFG_MCLK_HZ)

`endif

// ===== core/acfg_pkg.sv
// Types shared by the setup/filter configuration block
package acfg_pkg;

  typedef enum logic [1:0] {
    ACFG_REF_EXT_A = 2'h0,
    ACFG_REF_EXT_B = 2'h1,
    ACFG_REF_INT = 2'h2,
    ACFG_REF_SUPPLY = 2'h3
  } acfg_ref_t;

  typedef enum logic [3:0] {
    ACFG_FLT_SINC4 = 4'h0,
    ACFG_FLT_SINC4_AVG = 4'h1,
    ACFG_FLT_SINC3 = 4'h2,
    ACFG_FLT_SINC3_REJ = 4'h3,
    ACFG_FLT_SINC3_AVG = 4'h4,
    ACFG_FLT_POST1 = 4'h5,
    ACFG_FLT_POST2 = 4'h6,
    ACFG_FLT_POST3 = 4'h7,
    ACFG_FLT_POST4 = 4'h8
  } acfg_fmode_t;

  typedef struct packed {
    logic [9:0] other;
    acfg_ref_t ref_sel;
    logic [2:0] amp_gain_code;
    logic amp_bypass;
  } acfg_setup_t;

  typedef struct packed {
    logic [2:0] settle_wait_code;
    logic [4:0] repeat_count;
    logic [3:0] mode;
    logic rsvd;
    logic [10:0] rate_divider;
  } acfg_filter_t;

  typedef struct packed {
    logic neg_ref_buffer_on;
    acfg_ref_t ref_sel;
    logic [2:0] amp_gain_code;
    logic [7:0] gain_factor;
    acfg_fmode_t filter_mode;
    logic mode_reserved;
    logic sixty_hz_notch;
    logic fixed_output_rate;
    logic [10:0] rate_divider;
  } acfg_active_t;

  typedef enum logic [2:0] {
    ACFG_ST_IDLE = 3'b001,
    ACFG_ST_SETTLE = 3'b010,
    ACFG_ST_CONVERT = 3'b100
  } acfg_state_t;

endpackage : acfg_pkg

// ===== core/acfg_settle_timer.sv
// Front-end settling wait counter in master clock ticks
`timescale 1ns/1ps
`include "acfg_defines.svh"
module acfg_settle_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mclk_en,
  input wire logic start,
  input wire logic [2:0] code,
  output logic done
);

  logic [12:0] cnt_q;
  logic [12:0] target_q;
  logic run_q;

  // Target latched at start so a register write mid-wait cannot shorten it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 13'h0000;
      target_q <= `ACFG_SETTLE_BASE;
      run_q <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_q <= 13'h0000;
        target_q <= 13'(`ACFG_SETTLE_BASE << code);
        run_q <= 1'b1;
      end else if (run_q && mclk_en) begin
        if (cnt_q + 13'h0001 == target_q) begin
          run_q <= 1'b0;
          done <= 1'b1;
        end
        cnt_q <= cnt_q + 13'h0001;
      end
    end
  end

endmodule : acfg_settle_timer

// ===== bench/acfg_top_properties.sv
// Port-level checks for the setup/filter configuration block
`timescale 1ns/1ps
module acfg_top_properties #(
  parameter int MCLK_DIV = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic chan_change,
  input wire logic [2:0] setup_sel,
  input wire logic conv_done,
  input wire logic conv_start,
  input wire logic chan_advance,
  input wire acfg_pkg::acfg_active_t active
);
  logic conv_q;
  logic first_q;
  logic [1:0] up_q;
  int unsigned wait_q;
  // Active lags reset release by one edge, so decode checks wait two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_q <= 2'h0;
      conv_q <= 1'b0;
    end else begin
      up_q <= {up_q[0], 1'b1};
      conv_q <= (chan_change || chan_advance) ? 1'b0 : (conv_start ? 1'b1 : conv_q);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= 0;
      first_q <= 1'b0;
    end else if (chan_change) begin
      wait_q <= 0;
      first_q <= 1'b1;
    end else begin
      wait_q <= wait_q + 1;
      if (conv_start) first_q <= 1'b0;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_live_done;
    conv_q && conv_done && !chan_change;
  endsequence
  a_ready_answer: assert property (s_setup |=> pready) else $error("no ready");
  a_error_paired: assert property (pslverr |-> pready) else $error("lone error");
  a_gain_power: assert property (up_q[1] |->
    active.gain_factor == (8'h01 << active.amp_gain_code)) else $error("gain");
  a_notch_code: assert property (up_q[1] |->
    active.sixty_hz_notch == (active.filter_mode == 4'h3)) else $error("notch");
  a_post_rate: assert property (up_q[1] |-> active.fixed_output_rate ==
    (active.filter_mode >= 4'h5 && active.filter_mode <= 4'h8)) else $error("post");
  a_reserved_mode: assert property (up_q[1] |->
    active.mode_reserved == (active.filter_mode > 4'h8)) else $error("reserved");
  a_rate_nonzero: assert property (up_q[1] |-> active.rate_divider != 11'h000)
    else $error("rate zero");
  a_start_single: assert property (conv_start |=> !conv_start) else $error("start");
  a_repeat_prompt: assert property (s_live_done |=> conv_start != chan_advance)
    else $error("no follow");
  // Lower bound only: the tick phase is free-running
  a_settle_floor: assert property (conv_start && first_q |-> wait_q >= 30 * MCLK_DIV)
    else $error("settle short");
endmodule : acfg_top_properties

bind acfg_top acfg_top_properties #(.MCLK_DIV(MCLK_DIV)) u_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .chan_change(chan_change), .setup_sel(setup_sel), .conv_done(conv_done),
  .conv_start(conv_start), .chan_advance(chan_advance), .active(active));

// ===== bench/acfg_top_bench.sv
// Register and sequencer tests for the setup/filter configuration block
`timescale 1ns/1ps
module acfg_top_bench;
  logic pclk, presetn, psel, penable, pwrite, chan_change, conv_done;
  logic pready, pslverr, conv_start, chan_advance, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] setup_sel;
  acfg_pkg::acfg_active_t active;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  // Master clock tick every second pclk keeps settle waits short in simulation
  localparam int mclk_div = 2;
  acfg_top #(.MCLK_DIV(mclk_div)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chan_change(chan_change), .setup_sel(setup_sel),
    .conv_done(conv_done), .conv_start(conv_start), .chan_advance(chan_advance),
    .active(active));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic test_done;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Waits on pready itself; only the cycle ceiling ends a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic run_chan(input logic [2:0] s, input int exp_n, input int ticks);
    int n;
    int t;
    int first;
    n = 0;
    t = 0;
    first = 0;
    @(posedge pclk);
    chan_change <= 1'b1;
    setup_sel <= s;
    @(posedge pclk);
    chan_change <= 1'b0;
    while (chan_advance !== 1'b1) begin
      @(posedge pclk);
      t++;
      conv_done <= conv_start;
      if (conv_start === 1'b1) begin
        if (n == 0) first = t;
        n++;
      end
    end
    chk("starts", exp_n, n);
    // Tick phase is free-running, so allow one tick plus pipeline slack
    chk("settle", 32'h1, {31'h0, first >= mclk_div * ticks &&
      first <= mclk_div * ticks + mclk_div + 3});
  endtask : run_chan
  initial begin
    {presetn, psel, penable, pwrite, chan_change, conv_done} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    setup_sel = 3'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h064, 32'h0);
    chk("cfg0", 32'h00000000, rd);
    apb(1'b0, 12'h0A0, 32'h0);
    chk("flt7", 32'h00002030, rd);
    apb(1'b0, 12'h200, 32'h0);
    chk("unmapped", 32'h00000001, {rd[30:0], err});
    for (int g = 0; g < 8; g++) begin
      apb(1'b1, 12'h064, g << 1);
      repeat (2) @(posedge pclk);
      chk("gain", 32'h1 << g, {24'h0, active.gain_factor});
      chk("negbuf", g[2], active.neg_ref_buffer_on);
    end
    apb(1'b1, 12'h064, 32'h0000003F);
    repeat (2) @(posedge pclk);
    chk("bypass", 32'h1801, {active.ref_sel, active.amp_gain_code, active.gain_factor});
    // Software keeps to defined filter codes and writes the reserved bit as zero
    for (int m = 0; m < 9; m++) begin
      apb(1'b1, 12'h084, m << 12);
      repeat (2) @(posedge pclk);
      chk("mode", {m[3:0], m == 3, m >= 5 && m <= 8, m > 8, 11'h001},
        {active.filter_mode, active.sixty_hz_notch, active.fixed_output_rate,
        active.mode_reserved, active.rate_divider});
    end
    apb(1'b0, 12'h084, 32'h0);
    chk("rsvd", 32'h00008000, rd);
    apb(1'b1, 12'h088, 32'h00222030);
    // Control bit 0 is duty cycling, bit 1 calibration: either drops repeats
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, 12'h100, c);
      run_chan(3'h1, c == 0 ? 3 : 1, 64);
    end
    chk("slot", 32'h30, active.rate_divider);
    test_done();
  end
endmodule : acfg_top_bench
